// ==== core/pol_cfg_defines.vh ====
// Register offsets, field positions and timing counts of the configuration bank.
// Assumes a 100 MHz system clock.
`ifndef POL_CFG_DEFINES_VH
`define POL_CFG_DEFINES_VH
`define OFS_CURRENT_SENSE_SETUP 8'hD0
`define OFS_MISC_DEVICE_CONFIG 8'hD1
`define OFS_GROUP_BUS_SHARING_CONFIG 8'hD3
`define OFS_PG_ASSERT_DELAY 8'hD4
`define CS_BLANK_HI 15
`define CS_BLANK_LO 11
`define CS_FCOUNT_HI 10
`define CS_FCOUNT_LO 8
`define CS_METHOD_HI 3
`define CS_METHOD_LO 2
`define CS_RANGE_HI 1
`define CS_RANGE_LO 0
`define MISC_MINDUTY_HI 15
`define MISC_MINDUTY_LO 11
`define MISC_MINDUTY_EN 7
`define MISC_VSET_SEL 5
`define MISC_PWML_STATE 3
`define MISC_PG_PUSHPULL 2
`define MISC_EXT_TEMP_EN 1
`define MISC_EXT_TEMP_FAULT 0
`define GB_PHASE_HI 15
`define GB_PHASE_LO 13
`define GB_RAIL_HI 12
`define GB_RAIL_LO 8
`define GB_NPH_HI 2
`define GB_NPH_LO 0
`define SENSE_METHOD_SPS 2'h3
`define RANGE_25MV 2'h0
`define RANGE_35MV 2'h1
`define RANGE_50MV 2'h2
`define BLANK_STEP_NS 32
`define CLK_PERIOD_NS 10
`define MS_IN_NS 1000000
`define CYCLES_PER_MS (`MS_IN_NS / `CLK_PERIOD_NS)
`define PG_DELAY_MAX_MS 13'h1388
`define REG_RESET 16'h0000
`endif

// ==== core/event_run_counter.v ====
// Counts uninterrupted runs of per-cycle sense events against a threshold.
// Assumes cycleEnd pulses once per switching cycle.
`timescale 1ns/1ps
module event_run_counter (
    // Clock and reset
    input wire clk_sys,
    input wire rst_n,
    // Control
    input wire [2:0] faultCode,
    input wire eventIn,
    input wire cycleEnd,
    // Result
    output reg faultOut
);
    reg seen;
    reg [3:0] runCount;
    wire [3:0] threshold = {faultCode, 1'b1};
    wire [3:0] next_runCount = (runCount == 4'hF) ? runCount : runCount + 4'h1;

    // Several events inside one switching cycle collapse into one
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            seen <= 1'b0;
            runCount <= 4'h0;
            faultOut <= 1'b0;
        end else if (cycleEnd) begin
            seen <= 1'b0;
            if (seen || eventIn) begin // [RULE3]
                runCount <= next_runCount;
                faultOut <= (next_runCount >= threshold); // [RULE2]
            end else begin
                runCount <= 4'h0; // [RULE4]
                faultOut <= 1'b0;
            end
        end else if (eventIn) begin
            seen <= 1'b1;
        end
    end
endmodule // event_run_counter

// ==== core/pg_delay_timer.v ====
// Power-good assertion timer counting whole milliseconds.
// Assumes pgAbove is a level synchronous to clk_sys.
`timescale 1ns/1ps
`include "pol_cfg_defines.vh"
module pg_delay_timer #(
    parameter CYCLES_PER_MS = `CYCLES_PER_MS
) (
    // Clock and reset
    input wire clk_sys,
    input wire rst_n,
    // Control
    input wire [12:0] delayMs,
    input wire pgAbove,
    // Result
    output reg pgReady
);
    reg [31:0] subCount;
    reg [12:0] msCount;
    wire msTick = (subCount == CYCLES_PER_MS - 1);

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            subCount <= 32'h0;
            msCount <= 13'h0;
            pgReady <= 1'b0;
        end else if (!pgAbove) begin
            subCount <= 32'h0;
            msCount <= 13'h0;
            pgReady <= 1'b0;
        end else if (msCount >= delayMs) begin
            pgReady <= 1'b1; // [RULE17]
        end else if (msTick) begin
            subCount <= 32'h0;
            msCount <= msCount + 13'h1;
        end else begin
            subCount <= subCount + 32'h1;
        end
    end
endmodule // pg_delay_timer

// ==== core/pol_sense_group_pg_config.v ====
// Configuration word bank of a point-of-load controller: current sense,
// miscellaneous, group bus and power-good delay words, with their effects.
// Assumes a word-wide host port already decoded from the management bus.
//
// Overview of operation
// [RULE1] Blanking bits 15:11, 32 ns per step
// [RULE2] Fault count code n needs 2n+1 events
// [RULE3] At most one event per switching cycle
// [RULE4] Eventless switching cycle clears the run counter
// [RULE5] Bits 3:2 select method, 11 smart stage
// [RULE6] Bits 1:0 select 25, 35, 50 mV
// [RULE7] Min duty is 2(value+1)/512 of period
// [RULE8] Bit 7 enables the minimum duty limit
// [RULE9] Bit 5 picks first or second setpoint
// [RULE10] Bit 2 open-drain or push-pull power good
// [RULE11] Bit 1 enables external sensor compensation
// [RULE12] Bit 0 picks fault temperature sensor
// [RULE13] Five-bit rail identifier in bits 12:8
// [RULE14] Host programs same rail id across group
// [RULE15] Bits 15:13 give phase position 1 to 8
// [RULE16] Bits 2:0 phase count, odd codes only
// [RULE17] Wait programmed delay before asserting power good
// [RULE18] Power good delay spans 0 to 5000 ms; with PG_FRAC_BITS of 4 the code reaches 4096 ms at most
// [RULE19] Delay rounded to nearest whole millisecond
`timescale 1ns/1ps
`include "pol_cfg_defines.vh"
module pol_sense_group_pg_config #(
    parameter CYCLES_PER_MS = `CYCLES_PER_MS,
    parameter PG_FRAC_BITS = 4
) (
    // Clock and reset
    input wire clk_sys,
    input wire rst_n,
    // Host word port
    input wire [7:0] cmdCode,
    input wire wrStrobe,
    input wire rdStrobe,
    input wire [15:0] wrData,
    output reg [15:0] rdData,
    output reg rdValid,
    output reg cmdNack,
    // Switching and sense events
    input wire cycleEnd,
    input wire overCurrentEvent,
    input wire underCurrentEvent,
    input wire [8:0] cycleCount,
    // Setpoints and temperatures
    input wire [15:0] firstSetpointInput,
    input wire [15:0] secondSetpointInput,
    input wire [15:0] internalTemp,
    input wire [15:0] externalTemp,
    // Power good
    input wire pgAboveThreshold,
    // Decoded controls
    output reg [9:0] blankingNs,
    output reg senseUseSmartStage,
    output reg [1:0] senseMethod,
    output reg [5:0] senseRangeMv,
    output reg currentFault,
    output reg [9:0] minDutyCycles,
    output reg minDutyActive,
    output reg minDutyForce,
    output reg pwmLowIdleHigh,
    output reg [15:0] setpointSel,
    output reg extSensorEnable,
    output reg [15:0] compTemp,
    output reg [15:0] faultTemp,
    output reg [4:0] railId,
    output reg [3:0] phasePosition,
    output reg [3:0] phaseCount,
    output reg phaseCountValid,
    output reg powerGoodOut,
    output reg powerGoodOe
);
    // ==========================================================
    // Register storage
    reg [15:0] currentSenseSetup;
    reg [15:0] miscDeviceConfig;
    reg [15:0] groupBusSharingConfig;
    reg [15:0] pgAssertDelay;

    wire hitCs = (cmdCode == `OFS_CURRENT_SENSE_SETUP);
    wire hitMisc = (cmdCode == `OFS_MISC_DEVICE_CONFIG);
    wire hitGb = (cmdCode == `OFS_GROUP_BUS_SHARING_CONFIG);
    wire hitPg = (cmdCode == `OFS_PG_ASSERT_DELAY);
    wire hitAny = hitCs | hitMisc | hitGb | hitPg;

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            currentSenseSetup <= `REG_RESET;
            miscDeviceConfig <= `REG_RESET;
            groupBusSharingConfig <= `REG_RESET;
            pgAssertDelay <= `REG_RESET;
        end else if (wrStrobe) begin
            if (hitCs) begin
                currentSenseSetup <= wrData;
            end
            if (hitMisc) begin
                miscDeviceConfig <= wrData;
            end
            if (hitGb) begin
                groupBusSharingConfig <= wrData;
            end
            if (hitPg) begin
                pgAssertDelay <= wrData;
            end
        end
    end

    // ==========================================================
    // Read port; unknown command codes are refused with a nack pulse
    reg [15:0] next_rdData;
    always @* begin
        next_rdData = 16'h0000;
        if (hitCs) begin
            next_rdData = currentSenseSetup;
        end else if (hitMisc) begin
            next_rdData = miscDeviceConfig;
        end else if (hitGb) begin
            next_rdData = groupBusSharingConfig;
        end else if (hitPg) begin
            next_rdData = pgAssertDelay;
        end
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdData <= 16'h0000;
            rdValid <= 1'b0;
            cmdNack <= 1'b0;
        end else begin
            rdValid <= rdStrobe & hitAny;
            cmdNack <= (rdStrobe | wrStrobe) & ~hitAny;
            if (rdStrobe & hitAny) begin
                rdData <= next_rdData;
            end
        end
    end

    // ==========================================================
    // Current sense decode
    wire [4:0] blankCode = currentSenseSetup[`CS_BLANK_HI:`CS_BLANK_LO];
    wire [2:0] faultCode = currentSenseSetup[`CS_FCOUNT_HI:`CS_FCOUNT_LO];
    wire [1:0] methodCode = currentSenseSetup[`CS_METHOD_HI:`CS_METHOD_LO];
    wire [1:0] rangeCode = currentSenseSetup[`CS_RANGE_HI:`CS_RANGE_LO];
    wire runFault;

    event_run_counter u_runCounter (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .faultCode(faultCode),
        .eventIn(overCurrentEvent | underCurrentEvent),
        .cycleEnd(cycleEnd),
        .faultOut(runFault)
    );

    reg [5:0] next_rangeMv;
    always @* begin
        case (rangeCode) // [RULE6]
            `RANGE_25MV: next_rangeMv = 6'd25;
            `RANGE_35MV: next_rangeMv = 6'd35;
            `RANGE_50MV: next_rangeMv = 6'd50;
            // Undefined code held at the widest range as the safe choice
            default: next_rangeMv = 6'd50;
        endcase
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            blankingNs <= 10'h000;
            senseUseSmartStage <= 1'b0;
            senseMethod <= 2'h0;
            senseRangeMv <= 6'h00;
            currentFault <= 1'b0;
        end else begin
            blankingNs <= {blankCode, 5'h00}; // [RULE1]
            senseUseSmartStage <= (methodCode == `SENSE_METHOD_SPS); // [RULE5]
            senseMethod <= methodCode; // [RULE5]
            senseRangeMv <= next_rangeMv; // [RULE6]
            currentFault <= runFault; // [RULE2]
        end
    end

    // ==========================================================
    // Miscellaneous decode
    wire [4:0] minDutyCode = miscDeviceConfig[`MISC_MINDUTY_HI:`MISC_MINDUTY_LO];
    // Duty in 1/512 period units: 2 * (value + 1)
    wire [9:0] minDutyUnits = {4'h0, minDutyCode, 1'b0} + 10'h002;
    wire minDutyEn = miscDeviceConfig[`MISC_MINDUTY_EN];

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            minDutyCycles <= 10'h000;
            minDutyActive <= 1'b0;
            minDutyForce <= 1'b0;
            pwmLowIdleHigh <= 1'b0;
            setpointSel <= 16'h0000;
            extSensorEnable <= 1'b0;
            compTemp <= 16'h0000;
            faultTemp <= 16'h0000;
        end else begin
            minDutyCycles <= minDutyUnits; // [RULE7]
            minDutyActive <= minDutyEn; // [RULE8]
            // Count of the 512-step switching cycle still below the floor
            minDutyForce <= minDutyEn & ({1'b0, cycleCount} < minDutyUnits); // [RULE8]
            pwmLowIdleHigh <= miscDeviceConfig[`MISC_PWML_STATE];
            setpointSel <= miscDeviceConfig[`MISC_VSET_SEL] ?
                secondSetpointInput : firstSetpointInput; // [RULE9]
            extSensorEnable <= miscDeviceConfig[`MISC_EXT_TEMP_EN]; // [RULE11]
            compTemp <= miscDeviceConfig[`MISC_EXT_TEMP_EN] ?
                externalTemp : internalTemp; // [RULE11]
            faultTemp <= miscDeviceConfig[`MISC_EXT_TEMP_FAULT] ?
                externalTemp : internalTemp; // [RULE12]
        end
    end

    // ==========================================================
    // Group bus decode
    wire [2:0] phaseCode = groupBusSharingConfig[`GB_PHASE_HI:`GB_PHASE_LO];
    wire [2:0] nphCode = groupBusSharingConfig[`GB_NPH_HI:`GB_NPH_LO];

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            railId <= 5'h00;
            phasePosition <= 4'h0;
            phaseCount <= 4'h0;
            phaseCountValid <= 1'b0;
        end else begin
            railId <= groupBusSharingConfig[`GB_RAIL_HI:`GB_RAIL_LO]; // [RULE13]
            phasePosition <= {1'b0, phaseCode} + 4'h1; // [RULE15]
            phaseCount <= {1'b0, nphCode} + 4'h1; // [RULE16]
            phaseCountValid <= nphCode[0]; // [RULE16]
        end
    end

    // ==========================================================
    // Power good delay: fixed-point ms rounded, then clamped
    localparam [12:0] PG_MAX = `PG_DELAY_MAX_MS;
    wire [16:0] roundedSum = {1'b0, pgAssertDelay} + (17'h1 << (PG_FRAC_BITS - 1));
    wire [16:0] roundedMs = roundedSum >> PG_FRAC_BITS; // [RULE19]
    wire [12:0] delayMs = (roundedMs > {4'h0, PG_MAX}) ? PG_MAX : roundedMs[12:0]; // [RULE18]
    wire pgReady;

    pg_delay_timer #(
        .CYCLES_PER_MS(CYCLES_PER_MS)
    ) u_pgTimer (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .delayMs(delayMs),
        .pgAbove(pgAboveThreshold),
        .pgReady(pgReady)
    );

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            powerGoodOut <= 1'b0;
            powerGoodOe <= 1'b1;
        end else begin
            powerGoodOut <= pgReady; // [RULE17]
            // Open-drain only pulls low; released line means power good
            powerGoodOe <= miscDeviceConfig[`MISC_PG_PUSHPULL] | ~pgReady; // [RULE10]
        end
    end
endmodule // pol_sense_group_pg_config

// ==== dv/pol_cfg_properties.sv ====
// Concurrent checks on the configuration bank's decoded outputs.
// Assumes the design latches a word on the strobe edge and decodes it on the next edge.
`timescale 1ns/1ps
module pol_cfg_properties (
    // Clock and reset
    input logic clk_sys,
    input logic rst_n,
    // Host port and inputs
    input logic [7:0] cmdCode,
    input logic wrStrobe,
    input logic [15:0] wrData,
    input logic [15:0] firstSetpointInput,
    input logic [15:0] secondSetpointInput,
    input logic pgAboveThreshold,
    // Decoded outputs
    input logic [9:0] blankingNs,
    input logic senseUseSmartStage,
    input logic [1:0] senseMethod,
    input logic [5:0] senseRangeMv,
    input logic currentFault,
    input logic [9:0] minDutyCycles,
    input logic [15:0] setpointSel,
    input logic [4:0] railId,
    input logic [3:0] phasePosition,
    input logic phaseCountValid,
    input logic powerGoodOut,
    input logic powerGoodOe
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    wire wrSense = wrStrobe && cmdCode == 8'hD0;
    wire wrMisc = wrStrobe && cmdCode == 8'hD1;
    wire wrGroup = wrStrobe && cmdCode == 8'hD3;
    // ============================================================
    // Decode of written words
    property p_blank;
        wrSense |-> ##2 blankingNs == {$past(wrData[15:11], 2), 5'h00};
    endproperty
    a_blank: assert property (p_blank) else $error("blanking time wrong");
    property p_method;
        wrSense |-> ##2 senseMethod == $past(wrData[3:2], 2)
            && senseUseSmartStage == (&$past(wrData[3:2], 2));
    endproperty
    a_method: assert property (p_method) else $error("sense method wrong");
    property p_range;
        wrSense |-> ##2 senseRangeMv == ($past(wrData[1:0], 2) == 2'h0 ? 6'h19 :
            $past(wrData[1:0], 2) == 2'h1 ? 6'h23 : 6'h32);
    endproperty
    a_range: assert property (p_range) else $error("sense range wrong");
    property p_minduty;
        wrMisc |-> ##2 minDutyCycles == {4'h0, $past(wrData[15:11], 2), 1'b0} + 10'h002;
    endproperty
    a_minduty: assert property (p_minduty) else $error("minimum duty wrong");
    property p_setpoint;
        wrMisc |-> ##2 setpointSel ==
            ($past(wrData[5], 2) ? secondSetpointInput : firstSetpointInput);
    endproperty
    a_setpoint: assert property (p_setpoint) else $error("setpoint source wrong");
    property p_rail;
        wrGroup |-> ##2 railId == $past(wrData[12:8], 2);
    endproperty
    a_rail: assert property (p_rail) else $error("rail id wrong");
    property p_phase;
        wrGroup |-> ##2 phasePosition == {1'b0, $past(wrData[15:13], 2)} + 4'h1
            && phaseCountValid == $past(wrData[0], 2);
    endproperty
    a_phase: assert property (p_phase) else $error("phase decode wrong");
    // ============================================================
    // Power good pin
    property p_pgoe;
        !powerGoodOut |-> powerGoodOe;
    endproperty
    a_pgoe: assert property (p_pgoe) else $error("low level not driven");
    // With a zero delay the pin rises two edges after the threshold, so look one edge back
    property p_pgrise;
        $rose(powerGoodOut) |-> $past(pgAboveThreshold);
    endproperty
    a_pgrise: assert property (p_pgrise) else $error("power good without threshold");
    c_fault: cover property ($rose(currentFault));
    c_pg: cover property ($rose(powerGoodOut));
    c_push: cover property (powerGoodOut && powerGoodOe);
endmodule // pol_cfg_properties

bind pol_sense_group_pg_config pol_cfg_properties chk_u (.clk_sys, .rst_n, .cmdCode,
    .wrStrobe, .wrData, .firstSetpointInput, .secondSetpointInput, .pgAboveThreshold,
    .blankingNs, .senseUseSmartStage, .senseMethod, .senseRangeMv, .currentFault,
    .minDutyCycles, .setpointSel, .railId, .phasePosition, .phaseCountValid,
    .powerGoodOut, .powerGoodOe);

// ==== dv/pmbus_host_model.sv ====
// Host side model: word writes and reads on the decoded command port.
// Assumes requests are taken on the rising edge; it drives on the falling edge.
`timescale 1ns/1ps
module pmbus_host_model #(
    parameter logic [4:0] GROUP_RAIL_ID = 5'h0B
) (
    // Clock
    input logic clk_sys,
    // Host word port
    output logic [7:0] cmdCode = 8'h00,
    output logic wrStrobe = 1'b0,
    output logic rdStrobe = 1'b0,
    output logic [15:0] wrData = 16'h0000,
    input logic [15:0] rdData,
    input logic rdValid,
    input logic cmdNack
);
    task automatic write_word(input logic [7:0] cmd, input logic [15:0] data);
        @(negedge clk_sys);
        cmdCode = cmd;
        wrData = data;
        wrStrobe = 1'b1;
        @(negedge clk_sys);
        wrStrobe = 1'b0;
        // Stale data flipped so a late capture cannot look right
        wrData = ~data;
        repeat (2) @(negedge clk_sys);
    endtask
    task automatic read_word(input logic [7:0] cmd, output logic [15:0] data,
        output logic nack, output logic valid);
        @(negedge clk_sys);
        cmdCode = cmd;
        rdStrobe = 1'b1;
        @(negedge clk_sys);
        rdStrobe = 1'b0;
        // Valid and nack stand for one cycle only: take them right after the taking edge
        data = rdData;
        nack = cmdNack;
        valid = rdValid;
    endtask
    // Every group member gets the same rail id
    task automatic join_group(input logic [2:0] pos, input logic [2:0] phases);
        write_word(8'hD3, {pos, GROUP_RAIL_ID, 5'h00, phases});
    endtask
endmodule // pmbus_host_model

// ==== dv/tb.sv ====
// Testbench of the configuration bank, driven through the host model.
// Assumes a millisecond shortened to four clocks.
`timescale 1ns/1ps
module tb;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] cmdCode;
    logic wrStrobe, rdStrobe, rdValid, cmdNack, currentFault, extSensorEnable;
    logic [15:0] wrData, rdData, faultTemp;
    logic cycleEnd = 1'b0;
    logic overCurrentEvent = 1'b0;
    logic underCurrentEvent = 1'b0;
    logic pgAboveThreshold = 1'b0;
    logic [8:0] cycleCount = 9'h000;
    logic [5:0] senseRangeMv;
    logic [9:0] minDutyCycles;
    logic [3:0] phasePosition, phaseCount;
    logic phaseCountValid, powerGoodOut, powerGoodOe;
    int nFail = 0;
    int totalChecks = 0;
    int cycles = 0;
    always #5 clk_sys = ~clk_sys;
    always @(negedge clk_sys) cycleCount <= cycleCount + 9'h001;
    pmbus_host_model host_u (.clk_sys, .cmdCode, .wrStrobe, .rdStrobe, .wrData, .rdData,
        .rdValid, .cmdNack);
    pol_sense_group_pg_config #(.CYCLES_PER_MS(4)) dut_u (.clk_sys, .rst_n, .cmdCode,
        .wrStrobe, .rdStrobe, .wrData, .rdData, .rdValid, .cmdNack, .cycleEnd,
        .overCurrentEvent, .underCurrentEvent, .cycleCount, .firstSetpointInput(16'h1234),
        .secondSetpointInput(16'hABCD), .internalTemp(16'h0123), .externalTemp(16'h0456),
        .pgAboveThreshold, .blankingNs(), .senseUseSmartStage(), .senseMethod(),
        .senseRangeMv, .currentFault, .minDutyCycles, .minDutyActive(), .minDutyForce(),
        .pwmLowIdleHigh(), .setpointSel(), .extSensorEnable, .compTemp(), .faultTemp,
        .railId(), .phasePosition, .phaseCount, .phaseCountValid, .powerGoodOut,
        .powerGoodOe);
    // ============================================================
    // Shared tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        totalChecks++;
        if (got !== exp) begin
            nFail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] cmd, input logic [15:0] exp, input logic expNack);
        logic [15:0] data;
        logic nack;
        logic valid;
        host_u.read_word(cmd, data, nack, valid);
        chk({15'h0000, nack}, {15'h0000, expNack});
        chk({15'h0000, valid}, {15'h0000, ~expNack});
        if (!expNack) chk(data, exp);
    endtask
    task automatic sw_cycle(input logic oc, input logic uc);
        overCurrentEvent = oc;
        underCurrentEvent = uc;
        repeat (2) @(negedge clk_sys);
        overCurrentEvent = 1'b0;
        underCurrentEvent = 1'b0;
        cycleEnd = 1'b1;
        @(negedge clk_sys);
        cycleEnd = 1'b0;
    endtask
    task automatic complete_run;
        $display("checks=%0d failures=%0d", totalChecks, nFail);
        if (nFail == 0 && totalChecks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 2000) begin
            nFail++;
            complete_run();
        end
    end
    // ============================================================
    // Main sequence
    initial begin
        repeat (4) @(negedge clk_sys);
        rst_n = 1'b1;
        rd(8'hD0, 16'h0000, 1'b0);
        rd(8'hD1, 16'h0000, 1'b0);
        rd(8'hD3, 16'h0000, 1'b0);
        rd(8'hD4, 16'h0000, 1'b0);
        rd(8'hD2, 16'h0000, 1'b1);
        chk({10'h000, senseRangeMv}, 16'h0019);
        chk({12'h000, phasePosition}, 16'h0001);
        chk({6'h00, minDutyCycles}, 16'h0002);
        for (int i = 0; i < 3; i++) begin
            host_u.write_word(8'hD0, {5'h1A, 3'h0, 4'h0, 2'h3, i[1:0]});
            chk({10'h000, senseRangeMv}, i == 0 ? 16'h0019 : i == 1 ? 16'h0023 : 16'h0032);
        end
        host_u.write_word(8'hD0, 16'h0100);
        sw_cycle(1'b1, 1'b0);
        sw_cycle(1'b0, 1'b1);
        sw_cycle(1'b0, 1'b0);
        sw_cycle(1'b1, 1'b0);
        sw_cycle(1'b1, 1'b0);
        repeat (2) @(negedge clk_sys);
        chk({15'h0000, currentFault}, 16'h0000);
        sw_cycle(1'b0, 1'b1);
        repeat (2) @(negedge clk_sys);
        chk({15'h0000, currentFault}, 16'h0001);
        host_u.write_word(8'hD1, 16'hF8A3);
        chk({15'h0000, extSensorEnable}, 16'h0001);
        chk(faultTemp, 16'h0456);
        chk({6'h00, minDutyCycles}, 16'h0040);
        host_u.write_word(8'hD1, 16'h0000);
        chk({15'h0000, extSensorEnable}, 16'h0000);
        chk(faultTemp, 16'h0123);
        for (int i = 0; i < 8; i++) begin
            host_u.join_group(i[2:0], i[2:0]);
            chk({12'h000, phaseCount}, 16'(i + 1));
            chk({15'h0000, phaseCountValid}, 16'(i % 2));
            chk({12'h000, phasePosition}, 16'(i + 1));
        end
        rd(8'hD3, 16'hEB07, 1'b0);
        // Three and a half ms rounds up to four, sixteen clocks here
        host_u.write_word(8'hD4, 16'h0038);
        rd(8'hD4, 16'h0038, 1'b0);
        pgAboveThreshold = 1'b1;
        repeat (14) @(negedge clk_sys);
        chk({14'h0000, powerGoodOut, powerGoodOe}, 16'h0001);
        repeat (8) @(negedge clk_sys);
        chk({14'h0000, powerGoodOut, powerGoodOe}, 16'h0002);
        host_u.write_word(8'hD1, 16'h0004);
        chk({14'h0000, powerGoodOut, powerGoodOe}, 16'h0003);
        pgAboveThreshold = 1'b0;
        repeat (3) @(negedge clk_sys);
        chk({14'h0000, powerGoodOut, powerGoodOe}, 16'h0001);
        complete_run();
    end
endmodule // tb
